//--- verilog/sss_map.vh
`ifndef SSS_MAP_VH
`define SSS_MAP_VH

// ----------------------------------------
// clock and timing figures
// ----------------------------------------
`define SSS_CLK_KHZ         32'd25000
`define SSS_PG_TIMEOUT_US   32'd6250
`define SSS_RST_TIMEOUT_MS  32'd200
`define SSS_WD_INIT_MS      32'd102400
`define SSS_WD_NORM_MS      32'd1600

// ----------------------------------------
// reset values of the output stages
// ----------------------------------------
`define SSS_PG_RST          1'b0
`define SSS_RESET_RST       1'b0
`define SSS_WDF_RST         1'b1

// ----------------------------------------
// watchdog period strap encoding
// ----------------------------------------
`define SSS_WD_CFG_OFF      1'b0
`define SSS_WD_CFG_DEFAULT  1'b1

`endif

//--- verilog/sss_supervisor.v
`timescale 1ns/1ps
`include "sss_map.vh"

// Contract
// - power-good low while its supply is low or enable_n is high.
// - power-good releases after 6.25 ms clear; any recurrence restarts the wait.
// - reset low while any supply is low or manual_reset_n is low.
// - after all reset causes clear, reset stays low one full timeout, then releases.
// - kick level steady beyond watchdog timeout drives watchdog fault low.
// - watchdog timer restarts on asserted reset and on every kick edge while margin is high; edges while margin is low are lost.
// - margin low freezes power-good, reset and watchdog fault outputs.
// - margin beats manual reset; reset keeps its present state.
// - unused margin floats or is tied high; floating reads inactive.
// - default watchdog timeout is 102.4 s initially, 1.6 s in normal mode.
// - watchdog period strap low disables the watchdog completely.
module sss_supervisor #(
	parameter        NCH         = 8,
	parameter [31:0] PG_CYC      = `SSS_PG_TIMEOUT_US * `SSS_CLK_KHZ / 32'd1000,
	parameter [31:0] RST_CYC     = `SSS_RST_TIMEOUT_MS * `SSS_CLK_KHZ,
	parameter [31:0] WD_INIT_CYC = `SSS_WD_INIT_MS * `SSS_CLK_KHZ,
	parameter [31:0] WD_NORM_CYC = `SSS_WD_NORM_MS * `SSS_CLK_KHZ
) (
	input  wire           clk_i,
	input  wire           sys_rst_i,
	input  wire [NCH-1:0] supply_low_i,
	input  wire           enable_n_i,
	input  wire           manual_reset_n_i,
	input  wire           margin_n_i,
	input  wire           watchdog_kick_in_i,
	input  wire           watchdog_period_cfg_i,
	output reg  [NCH-1:0] power_good_out_n_o,
	output reg  [NCH-1:0] power_good_oe_o,
	output reg            reset_out_n_o,
	output reg            reset_oe_o,
	output reg            watchdog_fault_out_n_o,
	output reg            watchdog_fault_oe_o
);

	localparam SW = NCH + 5;

	// ----------------------------------------
	// input synchronisers
	// ----------------------------------------
	wire [SW-1:0] raw_in;
	reg  [SW-1:0] sync_s1;
	reg  [SW-1:0] sync_s2;
	reg  [SW-1:0] sync_s3;
	reg  [SW-1:0] clean;

	assign raw_in = {watchdog_period_cfg_i,
			watchdog_kick_in_i,
			margin_n_i,
			manual_reset_n_i,
			enable_n_i,
			supply_low_i};

	// idle-safe values: supplies low, enable off, controls inactive, strap off
	// every stage shares them, so no false change follows reset
	localparam [SW-1:0] SYNC_RST = {2'h0, 3'h7, {NCH{1'b1}}};

	// stage one may go metastable; only stage two reads it
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			sync_s1 <= SYNC_RST;
			sync_s2 <= SYNC_RST;
			sync_s3 <= SYNC_RST;
			clean   <= SYNC_RST;
		end else begin
			sync_s1 <= raw_in;
			sync_s2 <= sync_s1;
			sync_s3 <= sync_s2;
			// a change counts once stages two and three agree
			clean   <= (sync_s2 & ~(sync_s2 ^ sync_s3)) | (clean & (sync_s2 ^ sync_s3));
		end
	end

	wire [NCH-1:0] low_q    = clean[NCH-1:0];
	wire           en_off   = clean[NCH];
	wire           mr_act   = ~clean[NCH+1];
	wire           margin   = ~clean[NCH+2];
	wire           kick_q   = clean[NCH+3];
	wire           wd_cfg   = clean[NCH+4];

	// ----------------------------------------
	// shared timeout step
	// ----------------------------------------
	// true once a running count has reached its last cycle
	function cnt_done;
		input [31:0] cnt;
		input [31:0] lim;
		begin
			cnt_done = (cnt >= lim - 32'd1);
		end
	endfunction

	// saturates so a long hold cannot wrap the count
	function [31:0] step_cnt;
		input [31:0] cnt;
		input [31:0] lim;
		begin
			if (cnt_done(cnt, lim))
				step_cnt = cnt;
			else
				step_cnt = cnt + 32'd1;
		end
	endfunction

	// ----------------------------------------
	// power-good channels
	// ----------------------------------------
	reg [31:0] pg_cnt [0:NCH-1];
	integer    i;

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			for (i = 0; i < NCH; i = i + 1) begin
				pg_cnt[i]             <= 32'h0;
				power_good_out_n_o[i] <= `SSS_PG_RST;
				power_good_oe_o[i]    <= ~`SSS_PG_RST;
			end
		end else if (!margin) begin
			// each channel restarts its own wait from zero
			for (i = 0; i < NCH; i = i + 1) begin
				if (low_q[i] || en_off) begin
					pg_cnt[i]             <= 32'h0;
					power_good_out_n_o[i] <= 1'b0;
					power_good_oe_o[i]    <= 1'b1;
				end else if (!power_good_out_n_o[i]) begin
					if (cnt_done(pg_cnt[i], PG_CYC)) begin
						power_good_out_n_o[i] <= 1'b1;
						power_good_oe_o[i]    <= 1'b0;
					end else begin
						pg_cnt[i] <= step_cnt(pg_cnt[i], PG_CYC);
					end
				end
			end
		end
	end

	// ----------------------------------------
	// system reset output
	// ----------------------------------------
	reg [31:0] rst_cnt;

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			rst_cnt       <= 32'h0;
			reset_out_n_o <= `SSS_RESET_RST;
			reset_oe_o    <= ~`SSS_RESET_RST;
		end else if (!margin) begin
			// margin wins over manual reset, so nothing here moves under it
			if ((|low_q) || mr_act) begin
				rst_cnt       <= 32'h0;
				reset_out_n_o <= 1'b0;
				reset_oe_o    <= 1'b1;
			end else if (!reset_out_n_o) begin
				if (cnt_done(rst_cnt, RST_CYC)) begin
					reset_out_n_o <= 1'b1;
					reset_oe_o    <= 1'b0;
				end else begin
					rst_cnt <= step_cnt(rst_cnt, RST_CYC);
				end
			end
		end
	end

	// ----------------------------------------
	// watchdog
	// ----------------------------------------
	reg [31:0] wd_cnt;
	reg        wd_init;
	reg        kick_prev;
	wire       kick_edge = kick_q ^ kick_prev;
	// initial mode lasts until the first kick edge after reset
	wire [31:0] wd_lim   = wd_init ? WD_INIT_CYC : WD_NORM_CYC;

	// kick history follows the pin even while margin holds the outputs
	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			kick_prev <= 1'b0;
		end else begin
			kick_prev <= kick_q;
		end
	end

	always @(posedge clk_i) begin
		if (sys_rst_i) begin
			wd_cnt                 <= 32'h0;
			wd_init                <= 1'b1;
			watchdog_fault_out_n_o <= `SSS_WDF_RST;
			watchdog_fault_oe_o    <= ~`SSS_WDF_RST;
		end else if (!margin) begin
			if (wd_cfg == `SSS_WD_CFG_OFF) begin
				wd_cnt                 <= 32'h0;
				wd_init                <= 1'b1;
				watchdog_fault_out_n_o <= 1'b1;
				watchdog_fault_oe_o    <= 1'b0;
			end else if (!reset_out_n_o) begin
				wd_cnt                 <= 32'h0;
				wd_init                <= 1'b1;
				watchdog_fault_out_n_o <= 1'b1;
				watchdog_fault_oe_o    <= 1'b0;
			end else if (kick_edge) begin
				wd_cnt                 <= 32'h0;
				wd_init                <= 1'b0;
				watchdog_fault_out_n_o <= 1'b1;
				watchdog_fault_oe_o    <= 1'b0;
			end else if (cnt_done(wd_cnt, wd_lim)) begin
				watchdog_fault_out_n_o <= 1'b0;
				watchdog_fault_oe_o    <= 1'b1;
			end else begin
				wd_cnt <= step_cnt(wd_cnt, wd_lim);
			end
		end
	end

endmodule

//--- sim/sss_supervisor_asserts.sv
`timescale 1ns/1ps
module sss_sup_chk #(parameter NCH = 8, PG_CYC = 20, RST_CYC = 30) (
	input wire           clk_i,
	input wire           sys_rst_i,
	input wire [NCH-1:0] supply_low_i,
	input wire           enable_n_i,
	input wire           manual_reset_n_i,
	input wire           margin_n_i,
	input wire           watchdog_kick_in_i,
	input wire           watchdog_period_cfg_i,
	input wire [NCH-1:0] power_good_out_n_o,
	input wire           reset_out_n_o,
	input wire           watchdog_fault_out_n_o
);
	reg [15:0] pc, rc;
	always @(posedge clk_i) pc <= (sys_rst_i | supply_low_i[0] | enable_n_i) ? 16'h0000 : pc + 16'h0001;
	always @(posedge clk_i) rc <= (sys_rst_i | (|supply_low_i) | ~manual_reset_n_i) ? 16'h0000 : rc + 16'h0001;
	default clocking @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	property p_pa; (margin_n_i && enable_n_i) [*7] |-> ~|power_good_out_n_o; endproperty
	a_pa: assert property (p_pa) else $error("pa");
	property p_pg; $rose(power_good_out_n_o[0]) |-> pc >= PG_CYC; endproperty
	a_pg: assert property (p_pg) else $error("pg");
	property p_ra; (margin_n_i && !manual_reset_n_i) [*7] |-> !reset_out_n_o; endproperty
	a_ra: assert property (p_ra) else $error("ra");
	property p_rs; $rose(reset_out_n_o) |-> rc >= RST_CYC; endproperty
	a_rs: assert property (p_rs) else $error("rs");
	property p_wk; margin_n_i [*5] ##1 $changed(watchdog_kick_in_i) ##1 margin_n_i [*6] |-> watchdog_fault_out_n_o; endproperty
	a_wk: assert property (p_wk) else $error("wk");
	property p_fr; !margin_n_i [*6] |=> $stable({power_good_out_n_o, reset_out_n_o, watchdog_fault_out_n_o}); endproperty
	a_fr: assert property (p_fr) else $error("fr");
	property p_mr; (!margin_n_i && !manual_reset_n_i) [*6] ##0 reset_out_n_o |=> reset_out_n_o; endproperty
	a_mr: assert property (p_mr) else $error("mr");
	property p_wd; (margin_n_i && !watchdog_period_cfg_i) [*7] |-> watchdog_fault_out_n_o; endproperty
	a_wd: assert property (p_wd) else $error("wd");
	cover property (!margin_n_i [*6]);
	cover property ($rose(reset_out_n_o));
	cover property ($fell(watchdog_fault_out_n_o));
endmodule
bind sss_supervisor sss_sup_chk #(.NCH(NCH), .PG_CYC(PG_CYC), .RST_CYC(RST_CYC)) sss_sup_chk_inst (.*);

//--- sim/sss_host_model.sv
`timescale 1ns/1ps
module sss_host_model (
	input  wire clk_i,
	input  wire run_i,
	output reg  kick_o = 1'b0
);
	reg [3:0] cnt = 4'h0;
	always @(posedge clk_i) cnt <= (cnt == 4'h9) ? 4'h0 : cnt + 4'h1;
	always @(posedge clk_i) if (run_i && cnt == 4'h0) kick_o <= ~kick_o;
endmodule

//--- sim/test_sss_supervisor.sv
`timescale 1ns/1ps
module test_sss_supervisor;
	reg clk_i = 1'b0, rst = 1'b1, en_n = 1'b0, mr_n = 1'b1, mg_n = 1'b1, cfg = 1'b1, run = 1'b0;
	reg  [7:0] sl = 8'h00;
	wire       kick, rst_n, wdf;
	wire       rst_oe, wdf_oe;
	wire [7:0] pg;
	wire [7:0] pg_oe;
	integer    n_errors = 0, checks_done = 0;
	always #20 clk_i = ~clk_i;
	sss_supervisor #(.PG_CYC(20), .RST_CYC(30), .WD_INIT_CYC(60), .WD_NORM_CYC(25)) sss_supervisor_inst (.clk_i,
		.sys_rst_i(rst), .supply_low_i(sl), .enable_n_i(en_n), .manual_reset_n_i(mr_n), .margin_n_i(mg_n),
		.watchdog_kick_in_i(kick), .watchdog_period_cfg_i(cfg), .power_good_out_n_o(pg), .power_good_oe_o(pg_oe),
		.reset_out_n_o(rst_n), .reset_oe_o(rst_oe), .watchdog_fault_out_n_o(wdf), .watchdog_fault_oe_o(wdf_oe));
	sss_host_model sss_host_model_inst (.clk_i, .run_i(run), .kick_o(kick));
	task test_done;
		if (n_errors == 0 && checks_done > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task chk(input integer n, input [9:0] e);
		repeat (n - 1) @(posedge clk_i);
		@(negedge clk_i);
		checks_done = checks_done + 2;
		if ({pg, rst_n, wdf} !== e) begin
			n_errors = n_errors + 1;
			$display("BAD outs exp %h got %h", e, {pg, rst_n, wdf});
		end
		if ({pg_oe, rst_oe, wdf_oe} !== ~e) begin
			n_errors = n_errors + 1;
			$display("BAD oe exp %h got %h", ~e, {pg_oe, rst_oe, wdf_oe});
		end
		@(posedge clk_i);
	endtask
	initial begin
		repeat (4) @(posedge clk_i);
		rst <= 1'b0;
		chk(12, 10'h001);
		chk(24, 10'h3FF);
		chk(40, 10'h3FF);
		chk(20, 10'h3FE);
		run <= 1'b1;
		chk(20, 10'h3FF);
		run <= 1'b0;
		chk(45, 10'h3FE);
		sl <= 8'h08;
		chk(8, 10'h3DD);
		sl <= 8'h00;
		chk(14, 10'h3DD);
		sl <= 8'h08;
		chk(4, 10'h3DD);
		sl <= 8'h00;
		chk(18, 10'h3DD);
		chk(10, 10'h3FD);
		en_n <= 1'b1;
		chk(16, 10'h003);
		en_n <= 1'b0;
		chk(30, 10'h3FF);
		mg_n <= 1'b0;
		chk(8, 10'h3FF);
		mr_n <= 1'b0;
		sl <= 8'h01;
		chk(20, 10'h3FF);
		mg_n <= 1'b1;
		chk(8, 10'h3F9);
		mr_n <= 1'b1;
		sl <= 8'h00;
		cfg <= 1'b0;
		chk(110, 10'h3FF);
		test_done;
	end
endmodule
